// *** design/wwdt_pkg.sv ***
// Package of timing constants and phase encodings for the windowed watchdog.
package wwdt_pkg;

  // Clock period in picoseconds (250 MHz).
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Reset pulse length, 150 us, as a least time rounded up to cycles.
  localparam int unsigned RST_PULSE_NS = 150000;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Power-up phase base 0.8 ms per (kilohm + 1); window 0.175 ms/kilohm + 1.2 ms.
  localparam int unsigned PWRUP_STEP_NS = 800000;
  localparam int unsigned WIN_STEP_NS = 175000;
  localparam int unsigned WIN_BASE_NS = 1200000;

  // Default select resistance in kilohms (within 33 to 680).
  localparam int unsigned SEL_RES_KOHM = 33;

  // Default cycle counts derived from the times above.
  localparam int unsigned PWRUP_CYC =
    PWRUP_STEP_NS * (SEL_RES_KOHM + 1) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned WIN_CYC =
    (WIN_STEP_NS * SEL_RES_KOHM + WIN_BASE_NS) / (CLK_PERIOD_PS / 1000);

  // Width of the cycle counters; covers 120 ms and long power-up phases.
  localparam int unsigned CNT_W = 32;

  // Reset output level while idle.
  localparam logic RST_OUT_IDLE = 1'b1;

  typedef enum logic [1:0] {
    WWDT_OFF,
    WWDT_PWRUP,
    WWDT_PERIOD,
    WWDT_PULSE
  } wwdt_phase_e;

endpackage

// *** design/wwdt_edge.sv ***
// Falling-edge detector for the watchdog strobe input.
`timescale 1ns/1ps
`default_nettype none
module wwdt_edge (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Strobe level in, one-cycle falling-edge pulse out.
  input wire logic level_in,
  output logic fall_pulse
);

  logic last_reg;

  // The previous level starts high, so a strobe already low at reset release counts as an edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_reg <= 1'b1;
    end else begin
      last_reg <= level_in;
    end
  end

  assign fall_pulse = last_reg & ~level_in;

endmodule
`default_nettype wire

// *** design/wwdt_top.sv ***
// Windowed watchdog timer supervising a host by its falling-edge strobes.
// Behaviour
// - Select input held low keeps watchdog off and reset output high.
// - After power-on reset output goes high and power-up phase counts, unwindowed.
// - Power-up timeout pulses reset output low, then power-up timer restarts.
// - Power-up phase length is 0.8 ms times (kilohms plus one).
// - Each low reset pulse lasts about 150 microseconds.
// - First strobe in power-up ends it, enables windows, starts a period.
// - Strobe valid only from half to full window length after period start.
// - Strobe inside open window restarts period, reset output stays high.
// - Strobe before window opens pulses reset low at once, clears counter.
// - After a reset pulse in windowed operation the next period starts at its rising end.
// - No strobe in whole period: reset pulses low when timer expires.
// - Window length is 0.175 ms per kilohm plus 1.2 ms.
// - Window lengths from about 7 ms to 120 ms are supported.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Host strobe.
  input wire logic watchdog_strobe_in,
  // Configuration in clock cycles, and disable.
  input wire logic window_length_select,
  input wire logic [W-1:0] window_cycles,
  input wire logic [W-1:0] powerup_cycles,
  input wire logic [W-1:0] pulse_cycles,
  // Watchdog reset and phase status.
  output logic watchdog_reset_out_n,
  output logic windowed_active
);

  wwdt_phase_e phase_reg;
  logic [W-1:0] cnt_reg;
  logic strobe_fall;
  logic disabled;
  logic win_open;
  logic expired;
  logic pulse_done;
  logic [W-1:0] limit;
  logic [W-1:0] low_run;

  wwdt_edge u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .level_in(watchdog_strobe_in),
    .fall_pulse(strobe_fall)
  );

  // A low select input stands for the floating pin: watchdog off.
  assign disabled = ~window_length_select;

  // A zero length is treated as one cycle.
  function automatic logic [W-1:0] min1(input logic [W-1:0] v);
    return (v == '0) ? {{(W-1){1'b0}}, 1'b1} : v;
  endfunction

  // Window opens at half the window length.
  assign win_open = cnt_reg >= (min1(window_cycles) >> 1);
  // Lengths arrive as cycle counts, so no resistor needs sensing.
  always_comb begin
    limit = min1(window_cycles);
    unique case (phase_reg)
      WWDT_OFF: limit = min1(window_cycles);
      WWDT_PWRUP: limit = min1(powerup_cycles);
      WWDT_PERIOD: limit = min1(window_cycles);
      WWDT_PULSE: limit = min1(pulse_cycles);
    endcase
  end
  assign expired = cnt_reg >= limit - 1'b1;
  assign pulse_done = cnt_reg >= min1(pulse_cycles) - 1'b1;

  // Phase sequencing.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_reg <= WWDT_PWRUP;
    end else if (disabled) begin
      phase_reg <= WWDT_OFF;
    end else begin
      unique case (phase_reg)
        WWDT_OFF: phase_reg <= WWDT_PWRUP;
        WWDT_PWRUP: begin
          if (strobe_fall) begin
            phase_reg <= WWDT_PERIOD;
          end else if (expired) begin
            phase_reg <= WWDT_PULSE;
          end
        end
        WWDT_PERIOD: begin
          if (strobe_fall && !win_open) begin
            phase_reg <= WWDT_PULSE;
          end else if (!strobe_fall && expired) begin
            phase_reg <= WWDT_PULSE;
          end
        end
        WWDT_PULSE: begin
          if (pulse_done) begin
            phase_reg <= windowed_active ? WWDT_PERIOD : WWDT_PWRUP;
          end
        end
      endcase
    end
  end

  // Cycle counter, cleared at every phase change or accepted strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n || disabled) begin
      cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        WWDT_OFF: cnt_reg <= '0;
        WWDT_PWRUP: cnt_reg <= (strobe_fall || expired) ? '0 : cnt_reg + 1'b1;
        WWDT_PERIOD: cnt_reg <= (strobe_fall || expired) ? '0 : cnt_reg + 1'b1;
        WWDT_PULSE: cnt_reg <= pulse_done ? '0 : cnt_reg + 1'b1;
      endcase
    end
  end

  // Remembers that windowed operation has begun.
  always_ff @(posedge mclk) begin
    if (!rst_n || disabled) begin
      windowed_active <= 1'b0;
    end else if (phase_reg == WWDT_PWRUP && strobe_fall) begin
      windowed_active <= 1'b1;
    end
  end

  // Reset output, loaded low exactly when the pulse phase is next, so it is low in the pulse phase.
  always_ff @(posedge mclk) begin
    if (!rst_n || disabled) begin
      watchdog_reset_out_n <= RST_OUT_IDLE;
    end else begin
      unique case (phase_reg)
        WWDT_PWRUP: watchdog_reset_out_n <= !(expired && !strobe_fall);
        WWDT_PERIOD:
          watchdog_reset_out_n <= !(strobe_fall ? !win_open : expired);
        WWDT_PULSE: watchdog_reset_out_n <= pulse_done;
        WWDT_OFF: watchdog_reset_out_n <= RST_OUT_IDLE;
      endcase
    end
  end

  // Helper for the checks: counts how long the reset output has been low.
  always_ff @(posedge mclk) begin
    if (!rst_n || disabled || watchdog_reset_out_n) begin
      low_run <= '0;
    end else begin
      low_run <= low_run + 1'b1;
    end
  end

  // Reset output is low exactly in the pulse phase.
  out_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (watchdog_reset_out_n == (phase_reg != WWDT_PULSE)))
    else $error("reset output disagrees with pulse phase");

  disabled_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(disabled) && disabled |-> watchdog_reset_out_n)
    else $error("reset output low while disabled");

  early_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && strobe_fall && !win_open && !disabled
    |=> !watchdog_reset_out_n)
    else $error("early strobe gave no reset pulse");

  good_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && strobe_fall && win_open && !disabled
    |=> watchdog_reset_out_n && cnt_reg == '0)
    else $error("valid strobe did not restart period");

  timeout_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && !strobe_fall && expired && !disabled
    |=> phase_reg == WWDT_PULSE)
    else $error("period expired without reset pulse");

  pwrup_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PWRUP && strobe_fall && !disabled
    |=> phase_reg == WWDT_PERIOD && windowed_active)
    else $error("first strobe did not enable windows");

  pwrup_retry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE && pulse_done && !windowed_active && !disabled
    |=> phase_reg == WWDT_PWRUP && watchdog_reset_out_n)
    else $error("power-up timer not restarted after pulse");

  pulse_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE && pulse_done && windowed_active && !disabled
    |=> phase_reg == WWDT_PERIOD && cnt_reg == '0)
    else $error("period did not start at pulse end");

  pulse_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE && !disabled && !pulse_done
    |=> phase_reg == WWDT_PULSE)
    else $error("reset pulse ended early");

  reset_idle_a: assert property (@(posedge mclk)
    !rst_n |=> watchdog_reset_out_n && !windowed_active && cnt_reg == '0 &&
    phase_reg == WWDT_PWRUP)
    else $error("reset left the watchdog busy");

  pulse_exact_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(watchdog_reset_out_n) && !$past(disabled) && $past(rst_n)
    |-> low_run == min1(pulse_cycles))
    else $error("reset pulse length differs from setting");

  off_enter_a: assert property (@(posedge mclk) disable iff (!rst_n)
    disabled |=> phase_reg == WWDT_OFF && cnt_reg == '0 && !windowed_active)
    else $error("disable did not stop the watchdog");

  off_leave_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_OFF && !disabled
    |=> phase_reg == WWDT_PWRUP && cnt_reg == '0 && watchdog_reset_out_n)
    else $error("enable did not restart power-up");

  off_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_OFF |-> watchdog_reset_out_n)
    else $error("reset output low while off");

  pwrup_timeout_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PWRUP && expired && !strobe_fall && !disabled
    |=> phase_reg == WWDT_PULSE && !watchdog_reset_out_n)
    else $error("power-up expiry gave no pulse");

  pwrup_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PWRUP && !expired && !strobe_fall && !disabled
    |=> phase_reg == WWDT_PWRUP && cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("power-up timer did not advance");

  pwrup_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PWRUP |-> cnt_reg < min1(powerup_cycles))
    else $error("power-up timer ran past its length");

  pulse_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE |-> cnt_reg < min1(pulse_cycles))
    else $error("pulse timer ran past its length");

  pulse_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE && !pulse_done && !disabled
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("pulse timer did not advance");

  period_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD |-> cnt_reg < min1(window_cycles))
    else $error("period timer ran past the window");

  period_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && !strobe_fall && !expired && !disabled
    |=> phase_reg == WWDT_PERIOD && cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("period timer did not advance");

  pwrup_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PWRUP && strobe_fall && !disabled
    |=> cnt_reg == '0 && watchdog_reset_out_n)
    else $error("first strobe did not clear the timer");

  early_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && strobe_fall && !win_open && !disabled
    |=> phase_reg == WWDT_PULSE && cnt_reg == '0)
    else $error("early strobe did not clear the counter");

  timeout_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && !strobe_fall && expired && !disabled
    |=> !watchdog_reset_out_n && cnt_reg == '0)
    else $error("expiry did not drive the output low");

  window_accept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD && strobe_fall && win_open && !disabled
    |=> phase_reg == WWDT_PERIOD)
    else $error("strobe in open window left the period");

  strobe_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PULSE && strobe_fall && !pulse_done && !disabled
    |=> phase_reg == WWDT_PULSE && !watchdog_reset_out_n)
    else $error("strobe cut a reset pulse short");

  active_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    windowed_active && !disabled |=> windowed_active)
    else $error("windowed operation dropped");

  fall_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_fall |-> !watchdog_strobe_in)
    else $error("edge seen while strobe high");

  period_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_reg == WWDT_PERIOD || phase_reg == WWDT_PWRUP
    |-> watchdog_reset_out_n)
    else $error("reset output low outside a pulse");

endmodule
`default_nettype wire

// *** testbench/wwdt_host.sv ***
// Host model that strobes the watchdog trigger with falling edges.
`timescale 1ns/1ps
`default_nettype none
module wwdt_host (
  // Clock.
  input wire logic mclk,
  // Request for one low strobe cycle.
  input wire logic fire,
  // Strobe line to the watchdog.
  output logic strobe
);
  logic strobe_reg = 1'b1;
  assign strobe = strobe_reg;
  always @(negedge mclk) begin
    strobe_reg <= ~fire;
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench with a cycle model of the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wwdt_pkg::*;
  localparam int WIN = 10;
  localparam int PWR = 20;
  localparam int PUL = 3;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fire = 1'b0;
  logic sel = 1'b1;
  logic [31:0] win_len = 32'(WIN);
  logic chk = 1'b1;
  logic strobe, out_n, act, ex_out, ex_win, prev, fall;
  int ph, cnt, cyc, bad_count, samples_checked;
  wwdt_host wwdt_host_inst (.mclk(mclk), .fire(fire), .strobe(strobe));
  wwdt_top #(.W(CNT_W)) wwdt_top_inst (
    .mclk(mclk), .rst_n(rst_n), .watchdog_strobe_in(strobe),
    .window_length_select(sel), .window_cycles(win_len),
    .powerup_cycles(32'(PWR)), .pulse_cycles(32'(PUL)),
    .watchdog_reset_out_n(out_n), .windowed_active(act));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // A strobe is too early while fewer than half the window cycles passed.
  function automatic logic too_early(input int c, input int w);
    return c < w / 2;
  endfunction
  task automatic start_pulse;
    ex_out = 1'b0;
    ph = 2;
    cnt = 0;
  endtask
  always @(posedge mclk) begin
    if (!rst_n || !sel) begin
      ex_out = 1'b1;
      ex_win = 1'b0;
      ph = rst_n ? 3 : 0;
      cnt = 0;
      prev = rst_n ? strobe : 1'b1;
    end else begin
      fall = prev & ~strobe;
      prev = strobe;
      if (ph == 3) begin
        ph = 0;
        cnt = 0;
      end else if (ph == 2) begin
        if (cnt == PUL - 1) begin
          ex_out = 1'b1;
          ph = int'(ex_win);
          cnt = 0;
        end else begin
          cnt++;
        end
      end else if (fall && ph == 1 && too_early(cnt, int'(win_len))) begin
        start_pulse();
      end else if (fall) begin
        ex_win = 1'b1;
        ph = 1;
        cnt = 0;
      end else if (cnt == (ph == 1 ? int'(win_len) : PWR) - 1) begin
        start_pulse();
      end else begin
        cnt++;
      end
    end
  end
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(negedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      give_verdict();
    end
    if (chk) begin
      check(out_n, ex_out);
      check(act, ex_win);
    end
  end
  task automatic strobe_after(input int gap);
    fire <= 1'b1;
    @(negedge mclk);
    fire <= 1'b0;
    repeat (gap + 1) @(negedge mclk);
  endtask
  initial begin
    int gap;
    int corner [8] = '{2, 3, 4, 5, 7, 8, 10, 14};
    gap = $urandom(32'hb2f1);
    repeat (5) @(negedge mclk);
    rst_n <= 1'b1;
    // Let the power-up phase run out twice before the first strobe.
    repeat (50) @(negedge mclk);
    for (int i = 0; i < 400; i++) begin
      gap = (i < 8) ? corner[i] : int'($urandom % 16);
      strobe_after(gap);
    end
    // Disable mid-run; the first two cycles after the switch are not judged.
    chk <= 1'b0;
    sel <= 1'b0;
    repeat (2) @(negedge mclk);
    chk <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      strobe_after(i);
    end
    // Re-enable with another window; power-up must begin afresh.
    win_len <= 32'h00000008 + ($urandom % 8);
    repeat (2) @(negedge mclk);
    sel <= 1'b1;
    repeat (30) @(negedge mclk);
    for (int i = 0; i < 100; i++) begin
      strobe_after(int'($urandom % 20));
    end
    // Reset again in mid-run, then strobe right after release.
    rst_n <= 1'b0;
    repeat (5) @(negedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      strobe_after(int'($urandom % 16));
    end
    repeat (30) @(negedge mclk);
    give_verdict();
  end
endmodule
`default_nettype wire
